/* src/pmc_ctx_save.sv */
// context store that keeps the interrupted mode and context while in management state
`timescale 1ns/100ps
module pmc_ctx_save
  import pmc_pkg::*;
#(
  parameter int CTX_W = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic save_stb,
  input wire pmc_mode_t mode_in,
  input wire logic [CTX_W-1:0] ctx_in,
  output pmc_mode_t mode_saved,
  output logic [CTX_W-1:0] ctx_saved
);
  typedef struct packed {
    pmc_mode_t mode;
    logic [CTX_W-1:0] ctx;
  } pmc_ctx_st_t;

  pmc_ctx_st_t st_r;
  pmc_ctx_st_t st_nxt;

  always_comb begin
    st_nxt = st_r;
    if (save_stb) begin
      st_nxt.mode = mode_in;
      st_nxt.ctx = ctx_in;
    end
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{mode: PMC_MODE_REAL, ctx: '0};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign mode_saved = st_r.mode;
  assign ctx_saved = st_r.ctx;
endmodule

/* src/pmc_mode_ctrl.sv */
// operating mode control: mode tracking, management entry and exit, per-mode limits
`timescale 1ns/100ps
module pmc_mode_ctrl
  import pmc_pkg::*;
#(
  parameter int CTX_W = 64
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic instr_boundary,
  input wire logic mgmt_irq_pin_n,
  input wire logic local_irq_controller_msg,
  input wire logic mgmt_resume,
  input wire logic [PMC_CTRL_W-1:0] sys_control_reg_first,
  input wire logic [PMC_CTRL_W-1:0] sys_control_reg_last,
  input wire logic [PMC_CTRL_W-1:0] ext_feature_ctrl,
  input wire logic [PMC_CTRL_W-1:0] flags_register,
  input wire logic [1:0] code_seg_attr,
  input wire logic reg_extension_prefix_w,
  input wire logic opsize_prefix,
  input wire logic [CTX_W-1:0] live_ctx,
  output pmc_mode_t cur_mode,
  output logic system_mgmt_state,
  output logic mgmt_addr_space,
  output logic mgmt_pending,
  output logic ctx_restore_stb,
  output logic [CTX_W-1:0] ctx_restore,
  output logic v86_active,
  output logic task_switch_en,
  output logic [1:0] addr_size,
  output logic [1:0] oper_size,
  output logic [6:0] lin_addr_bits,
  output logic [6:0] phys_addr_bits,
  output logic [4:0] gpr_count,
  output logic [4:0] simd_count,
  output logic [6:0] gpr_width,
  output logic [6:0] ip_width,
  output logic [6:0] flags_width,
  output logic [6:0] flags_impl_width,
  output logic [4:0] seg_count,
  output logic [2:0] gpr_subregs
);
  typedef struct packed {
    pmc_mode_t mode;
    logic pend;
    logic restore;
    logic [CTX_W-1:0] rctx;
    logic v86;
    logic tsk;
    logic [1:0] asz;
    logic [1:0] osz;
    logic [6:0] lin;
    logic [6:0] phys;
    logic [4:0] gprn;
    logic [6:0] gprw;
    logic smgt;
    logic [6:0] fiw;
    logic [4:0] segc;
    logic [2:0] subr;
  } pmc_state_t;

  pmc_state_t st_r;
  pmc_state_t st_nxt;
  pmc_mode_t saved_mode;
  logic [CTX_W-1:0] saved_ctx;
  logic save_stb;
  logic mgmt_req;
  pmc_mode_t normal_mode;

  // mode implied by control registers and the code segment descriptor
  function automatic pmc_mode_t decode_mode(input logic [PMC_CTRL_W-1:0] c0,
                                            input logic [PMC_CTRL_W-1:0] ef,
                                            input logic [1:0] attr);
    pmc_mode_t m;
    m = PMC_MODE_REAL;
    if (c0[PMC_CR0_PE_BIT]) begin
      m = PMC_MODE_PROT;
      if (c0[PMC_CR0_PG_BIT] && ef[PMC_LME_BIT]) begin
        m = attr[PMC_DESC_L_BIT] ? PMC_MODE_LONG64 : PMC_MODE_COMPAT;
      end
    end
    return m;
  endfunction

  assign mgmt_req = !mgmt_irq_pin_n || local_irq_controller_msg;
  assign normal_mode = decode_mode(sys_control_reg_first, ext_feature_ctrl,
                                   code_seg_attr);
  assign save_stb = clk_en && instr_boundary && (mgmt_req || st_r.pend)
                    && (st_r.mode != PMC_MODE_SYSMGT);

  pmc_ctx_save #(
    .CTX_W(CTX_W)
  ) u_ctx (
    .ref_clk(ref_clk),
    .rst(rst),
    .clk_en(clk_en),
    .save_stb(save_stb),
    .mode_in(st_r.mode),
    .ctx_in(live_ctx),
    .mode_saved(saved_mode),
    .ctx_saved(saved_ctx)
  );

  always_comb begin
    pmc_mode_t nm;
    nm = st_r.mode;
    st_nxt = st_r;
    st_nxt.restore = 1'b0;
    if (mgmt_req && st_r.mode == PMC_MODE_SYSMGT) begin
      st_nxt.pend = 1'b1;
    end
    if (instr_boundary) begin
      case (st_r.mode)
        PMC_MODE_SYSMGT: begin
          if (mgmt_resume) begin
            nm = saved_mode;
            st_nxt.restore = 1'b1;
            st_nxt.rctx = saved_ctx;
          end
        end
        PMC_MODE_REAL, PMC_MODE_PROT, PMC_MODE_COMPAT, PMC_MODE_LONG64: begin
          if (mgmt_req || st_r.pend) begin
            nm = PMC_MODE_SYSMGT;
            st_nxt.pend = 1'b0;
          end else begin
            nm = normal_mode;
          end
        end
        default: begin
          nm = PMC_MODE_REAL;
        end
      endcase
    end
    st_nxt.mode = nm;
    st_nxt.smgt = (nm == PMC_MODE_SYSMGT);
    st_nxt.fiw = PMC_FLAGS_IMPL_W;
    st_nxt.segc = PMC_SEG_COUNT;
    st_nxt.subr = PMC_SUB_BYTE | PMC_SUB_WORD | PMC_SUB_DWORD;
    // per-mode effects follow the next mode so they align with it
    st_nxt.v86 = (nm == PMC_MODE_PROT) && flags_register[PMC_FLAGS_VM_BIT];
    st_nxt.tsk = (nm == PMC_MODE_PROT);
    case (nm)
      PMC_MODE_LONG64: begin
        st_nxt.asz = PMC_SZ_64;
        st_nxt.osz = (reg_extension_prefix_w && opsize_prefix) ? PMC_SZ_64 : PMC_SZ_32;
        st_nxt.lin = PMC_LIN_BITS_LONG;
        st_nxt.phys = PMC_PHYS_BITS_LONG;
        st_nxt.gprn = PMC_GPR_LONG;
        st_nxt.gprw = PMC_GPR_W_LONG;
      end
      PMC_MODE_COMPAT, PMC_MODE_PROT: begin
        st_nxt.asz = code_seg_attr[PMC_DESC_D_BIT] ? PMC_SZ_32 : PMC_SZ_16;
        st_nxt.osz = code_seg_attr[PMC_DESC_D_BIT] ? PMC_SZ_32 : PMC_SZ_16;
        st_nxt.lin = PMC_LIN_BITS_LEGACY;
        st_nxt.phys = sys_control_reg_last[PMC_CR4_PAE_BIT] ? PMC_PHYS_BITS_LEGACY
                                                           : PMC_PHYS_BITS_NOPAE;
        st_nxt.gprn = PMC_GPR_LEGACY;
        st_nxt.gprw = PMC_GPR_W_LEGACY;
      end
      default: begin
        st_nxt.asz = PMC_SZ_16;
        st_nxt.osz = PMC_SZ_16;
        st_nxt.lin = (nm == PMC_MODE_REAL) ? PMC_LIN_BITS_REAL : PMC_LIN_BITS_LEGACY;
        st_nxt.phys = PMC_PHYS_BITS_LEGACY;
        st_nxt.gprn = PMC_GPR_LEGACY;
        st_nxt.gprw = PMC_GPR_W_LEGACY;
      end
    endcase
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_r <= '{mode: PMC_MODE_REAL,
                pend: 1'b0,
                restore: 1'b0,
                rctx: '0,
                v86: 1'b0,
                tsk: 1'b0,
                asz: PMC_SZ_16,
                osz: PMC_SZ_16,
                lin: PMC_LIN_BITS_REAL,
                phys: PMC_PHYS_BITS_LEGACY,
                gprn: PMC_GPR_LEGACY,
                gprw: PMC_GPR_W_LEGACY,
                smgt: 1'b0,
                fiw: PMC_FLAGS_IMPL_W,
                segc: PMC_SEG_COUNT,
                subr: PMC_SUB_BYTE | PMC_SUB_WORD | PMC_SUB_DWORD};
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign cur_mode = st_r.mode;
  assign system_mgmt_state = st_r.smgt;
  assign mgmt_addr_space = st_r.smgt;
  assign mgmt_pending = st_r.pend;
  assign ctx_restore_stb = st_r.restore;
  assign ctx_restore = st_r.rctx;
  assign v86_active = st_r.v86;
  assign task_switch_en = st_r.tsk;
  assign addr_size = st_r.asz;
  assign oper_size = st_r.osz;
  assign lin_addr_bits = st_r.lin;
  assign phys_addr_bits = st_r.phys;
  assign gpr_count = st_r.gprn;
  assign simd_count = st_r.gprn;
  assign gpr_width = st_r.gprw;
  assign ip_width = st_r.gprw;
  assign flags_width = st_r.gprw;
  assign flags_impl_width = st_r.fiw;
  assign seg_count = st_r.segc;
  assign gpr_subregs = st_r.subr;

  sequence s_req_at_boundary;
    instr_boundary && mgmt_req && st_r.mode != PMC_MODE_SYSMGT;
  endsequence
  sequence s_pend_at_boundary;
    instr_boundary && st_r.pend && st_r.mode != PMC_MODE_SYSMGT;
  endsequence
  sequence s_normal_at_boundary;
    instr_boundary && !mgmt_req && !st_r.pend && st_r.mode != PMC_MODE_SYSMGT;
  endsequence
  sequence s_in_mgmt;
    st_r.mode == PMC_MODE_SYSMGT;
  endsequence
  sequence s_resume_at_boundary;
    instr_boundary && mgmt_resume && st_r.mode == PMC_MODE_SYSMGT;
  endsequence

  AST_ENTER_MGMT: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_req_at_boundary) |=> s_in_mgmt)
    else $error("management request not taken at boundary");

  AST_SAVE_MODE: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_req_at_boundary) |=> saved_mode == $past(st_r.mode))
    else $error("interrupted mode not saved");

  AST_SAVE_CTX: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_req_at_boundary) |=> saved_ctx == $past(live_ctx))
    else $error("interrupted context not saved");

  AST_RESTORE: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_resume_at_boundary)
    |=> st_r.mode == $past(saved_mode) && st_r.restore)
    else $error("resume did not restore saved mode");

  AST_RESTORE_CTX: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_resume_at_boundary) |=> st_r.rctx == $past(saved_ctx))
    else $error("resume did not present saved context");

  AST_RESTORE_PULSE: assert property (@(posedge ref_clk) disable iff (rst)
    clk_en && st_r.restore |=> !st_r.restore)
    else $error("restore strobe longer than one cycle");

  AST_PENDING: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_in_mgmt) ##0 (mgmt_req && !(instr_boundary && mgmt_resume))
    |=> st_r.pend and s_in_mgmt)
    else $error("nested management request not held");

  AST_PEND_ENTER: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_pend_at_boundary) |=> !st_r.pend and s_in_mgmt)
    else $error("held management request not taken");

  AST_NORMAL: assert property (@(posedge ref_clk) disable iff (rst)
    (clk_en and s_normal_at_boundary) |=> st_r.mode == $past(normal_mode))
    else $error("mode does not follow control registers");

  AST_STABLE: assert property (@(posedge ref_clk) disable iff (rst)
    !instr_boundary |=> st_r.mode == $past(st_r.mode))
    else $error("mode changed off boundary");

  AST_FROZEN: assert property (@(posedge ref_clk) disable iff (rst)
    !clk_en |=> st_r == $past(st_r))
    else $error("state moved with clock enable low");

  AST_MODE_LEGAL: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.mode <= PMC_MODE_SYSMGT)
    else $error("mode register holds an unused code");

  AST_V86: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.v86 |-> st_r.mode == PMC_MODE_PROT)
    else $error("v86 outside protected mode");

  AST_TASK_PROT: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.tsk |-> st_r.mode == PMC_MODE_PROT)
    else $error("task switching outside protected mode");

  AST_LONG_SIZES: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.mode == PMC_MODE_LONG64 |-> st_r.asz == PMC_SZ_64 && st_r.gprn == PMC_GPR_LONG)
    else $error("64-bit sub-mode sizes wrong");

  AST_OPSIZE64: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.osz == PMC_SZ_64 |-> st_r.mode == PMC_MODE_LONG64)
    else $error("64-bit operands outside 64-bit sub-mode");

  AST_WIDE_REGS: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.mode == PMC_MODE_LONG64 |-> st_r.gprw == PMC_GPR_W_LONG
    && st_r.fiw == PMC_FLAGS_IMPL_W)
    else $error("64-bit register widths wrong");

  AST_LEGACY_LIMITS: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.mode != PMC_MODE_LONG64 |-> st_r.lin <= PMC_LIN_BITS_LEGACY
    && st_r.phys <= PMC_PHYS_BITS_LEGACY && st_r.gprn == PMC_GPR_LEGACY)
    else $error("legacy address limits exceeded");

  AST_REAL_LIMITS: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.mode == PMC_MODE_REAL |-> st_r.lin == PMC_LIN_BITS_REAL && st_r.asz == PMC_SZ_16)
    else $error("real-address limits wrong");

  AST_COMPAT: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.mode == PMC_MODE_COMPAT |-> !st_r.v86 && !st_r.tsk && st_r.asz != PMC_SZ_64)
    else $error("compatibility features wrong");

  AST_COMPAT_SIZES: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.mode != PMC_MODE_LONG64 |-> st_r.asz != PMC_SZ_64 && st_r.osz != PMC_SZ_64)
    else $error("64-bit sizes outside 64-bit sub-mode");

  AST_SUBREGS: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.subr == (PMC_SUB_BYTE | PMC_SUB_WORD | PMC_SUB_DWORD))
    else $error("byte or word register view missing");

  AST_SEGMENTS: assert property (@(posedge ref_clk) disable iff (rst)
    st_r.segc == PMC_SEG_COUNT)
    else $error("segment register count wrong");
endmodule

/* src/pmc_pkg.sv */
// package with mode encodings, control bit positions and size constants for mode control
package pmc_pkg;
  typedef enum logic [2:0] {
    PMC_MODE_REAL   = 3'h0,
    PMC_MODE_PROT   = 3'h1,
    PMC_MODE_COMPAT = 3'h2,
    PMC_MODE_LONG64 = 3'h3,
    PMC_MODE_SYSMGT = 3'h4
  } pmc_mode_t;

  localparam int PMC_NUM_CTRL = 5;
  localparam int PMC_CTRL_W = 32;
  localparam int PMC_CR0_PE_BIT = 0;
  localparam int PMC_CR0_PG_BIT = 31;
  localparam int PMC_CR4_PAE_BIT = 5;
  localparam int PMC_LME_BIT = 8;
  localparam int PMC_FLAGS_VM_BIT = 17;
  localparam int PMC_DESC_L_BIT = 0;
  localparam int PMC_DESC_D_BIT = 1;

  localparam logic [1:0] PMC_SZ_16 = 2'h0;
  localparam logic [1:0] PMC_SZ_32 = 2'h1;
  localparam logic [1:0] PMC_SZ_64 = 2'h2;

  localparam logic [6:0] PMC_LIN_BITS_LEGACY = 7'h20;
  localparam logic [6:0] PMC_LIN_BITS_REAL = 7'h14;
  localparam logic [6:0] PMC_LIN_BITS_LONG = 7'h40;
  localparam logic [6:0] PMC_PHYS_BITS_LEGACY = 7'h24;
  localparam logic [6:0] PMC_PHYS_BITS_NOPAE = 7'h20;
  localparam logic [6:0] PMC_PHYS_BITS_LONG = 7'h28;

  localparam logic [4:0] PMC_GPR_LEGACY = 5'h08;
  localparam logic [4:0] PMC_GPR_LONG = 5'h10;
  localparam logic [4:0] PMC_SEG_COUNT = 5'h06;
  localparam logic [6:0] PMC_GPR_W_LEGACY = 7'h20;
  localparam logic [6:0] PMC_GPR_W_LONG = 7'h40;
  localparam logic [6:0] PMC_FLAGS_IMPL_W = 7'h20;

  localparam logic [2:0] PMC_SUB_BYTE = 3'h1;
  localparam logic [2:0] PMC_SUB_WORD = 3'h2;
  localparam logic [2:0] PMC_SUB_DWORD = 3'h4;
endpackage

/* verification/pmc_plat_model.sv */
// platform and operating system model: management requests and control registers
`timescale 1ns/100ps
module pmc_plat_model
  import pmc_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire pmc_mode_t os_goal,
  input wire logic smi_req,
  input wire logic msg_req,
  output logic mgmt_irq_pin_n,
  output logic local_irq_controller_msg,
  output logic [PMC_CTRL_W-1:0] sys_control_reg_first,
  output logic [PMC_CTRL_W-1:0] sys_control_reg_last,
  output logic [PMC_CTRL_W-1:0] ext_feature_ctrl,
  output logic [1:0] code_seg_attr
);
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mgmt_irq_pin_n <= 1'b1;
      local_irq_controller_msg <= 1'b0;
      sys_control_reg_first <= '0;
      sys_control_reg_last <= '0;
      ext_feature_ctrl <= '0;
      code_seg_attr <= 2'h0;
    end else begin
      // pin pulled high when idle, low one cycle after smi_req for as many cycles as smi_req is high
      mgmt_irq_pin_n <= !smi_req;
      local_irq_controller_msg <= msg_req;
      sys_control_reg_first <= '0;
      sys_control_reg_last <= '0;
      ext_feature_ctrl <= '0;
      code_seg_attr <= 2'h0;
      if (os_goal != PMC_MODE_REAL) begin
        sys_control_reg_first[PMC_CR0_PE_BIT] <= 1'b1;
        sys_control_reg_last[PMC_CR4_PAE_BIT] <= 1'b1;
      end
      if (os_goal == PMC_MODE_COMPAT || os_goal == PMC_MODE_LONG64) begin
        sys_control_reg_first[PMC_CR0_PG_BIT] <= 1'b1;
        ext_feature_ctrl[PMC_LME_BIT] <= 1'b1;
        // descriptor picked before the segment runs
        code_seg_attr <= (os_goal == PMC_MODE_LONG64) ? 2'h1 : 2'h2;
      end
    end
  end
endmodule

/* verification/tb.sv */
// testbench for operating mode control
`timescale 1ns/100ps
`define CK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
  $display("[ERR] %s exp %0h got %0h", n, e, g); end end
module tb;
  import pmc_pkg::*;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic clk_en = 1'b1;
  logic instr_boundary = 1'b1;
  logic mgmt_resume = 1'b0;
  logic smi_req = 1'b0;
  logic msg_req = 1'b0;
  logic rex_w = 1'b0;
  logic opsz = 1'b0;
  logic [31:0] flags_register = '0;
  logic [63:0] live_ctx = '0;
  pmc_mode_t os_goal = PMC_MODE_REAL;
  logic pin_n, msg, sms, mas, pend, stb, v86, tsw;
  logic [31:0] cr_first, cr_last, ext_ctrl;
  logic [1:0] attr, asz, osz;
  pmc_mode_t cur_mode;
  logic [63:0] ctx_restore;
  logic [6:0] lin, phys, gpw, ipw, flw, fiw;
  logic [4:0] gpc, smc, segc;
  logic [2:0] subr;
  int fails = 0;
  int comparisons = 0;
  always #2.5 ref_clk = ~ref_clk;
  pmc_plat_model u_pmc_plat_model (.ref_clk(ref_clk), .rst(rst), .os_goal(os_goal),
    .smi_req(smi_req), .msg_req(msg_req), .mgmt_irq_pin_n(pin_n),
    .local_irq_controller_msg(msg), .sys_control_reg_first(cr_first),
    .sys_control_reg_last(cr_last), .ext_feature_ctrl(ext_ctrl), .code_seg_attr(attr));
  pmc_mode_ctrl #(.CTX_W(64)) u_pmc_mode_ctrl (.ref_clk(ref_clk), .rst(rst),
    .clk_en(clk_en), .instr_boundary(instr_boundary), .mgmt_irq_pin_n(pin_n),
    .local_irq_controller_msg(msg), .mgmt_resume(mgmt_resume),
    .sys_control_reg_first(cr_first), .sys_control_reg_last(cr_last),
    .ext_feature_ctrl(ext_ctrl), .flags_register(flags_register), .code_seg_attr(attr),
    .reg_extension_prefix_w(rex_w), .opsize_prefix(opsz), .live_ctx(live_ctx),
    .cur_mode(cur_mode), .system_mgmt_state(sms), .mgmt_addr_space(mas),
    .mgmt_pending(pend), .ctx_restore_stb(stb), .ctx_restore(ctx_restore),
    .v86_active(v86), .task_switch_en(tsw), .addr_size(asz), .oper_size(osz),
    .lin_addr_bits(lin), .phys_addr_bits(phys), .gpr_count(gpc), .simd_count(smc),
    .gpr_width(gpw), .ip_width(ipw), .flags_width(flw), .flags_impl_width(fiw),
    .seg_count(segc), .gpr_subregs(subr));
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic go(input pmc_mode_t m);
    @(posedge ref_clk);
    os_goal <= m;
    settle(4);
  endtask
  task automatic pulse(input logic use_pin);
    @(posedge ref_clk);
    if (use_pin) smi_req <= 1'b1;
    else msg_req <= 1'b1;
    @(posedge ref_clk);
    smi_req <= 1'b0;
    msg_req <= 1'b0;
    settle(3);
  endtask
  task automatic resume();
    @(posedge ref_clk);
    mgmt_resume <= 1'b1;
    @(posedge ref_clk);
    mgmt_resume <= 1'b0;
    #1;
  endtask
  task automatic t_reset();
    `CK("mode", PMC_MODE_REAL, cur_mode)
    `CK("asz", PMC_SZ_16, asz)
    `CK("lin", PMC_LIN_BITS_REAL, lin)
    `CK("phys", PMC_PHYS_BITS_LEGACY, phys)
    `CK("gpc", PMC_GPR_LEGACY, gpc)
    `CK("seg", PMC_SEG_COUNT, segc)
    `CK("fiw", PMC_FLAGS_IMPL_W, fiw)
    `CK("subr", PMC_SUB_BYTE | PMC_SUB_WORD | PMC_SUB_DWORD, subr)
  endtask
  task automatic t_prot_v86();
    go(PMC_MODE_PROT);
    `CK("mode", PMC_MODE_PROT, cur_mode)
    @(posedge ref_clk);
    flags_register <= 32'h1 << PMC_FLAGS_VM_BIT;
    settle(3);
    `CK("v86", 1'b1, v86)
    `CK("tsw", 1'b1, tsw)
    `CK("mode", PMC_MODE_PROT, cur_mode)
    `CK("lin", PMC_LIN_BITS_LEGACY, lin)
    `CK("phys", PMC_PHYS_BITS_LEGACY, phys)
  endtask
  task automatic t_compat();
    go(PMC_MODE_COMPAT);
    `CK("mode", PMC_MODE_COMPAT, cur_mode)
    `CK("v86", 1'b0, v86)
    `CK("tsw", 1'b0, tsw)
    `CK("lin", PMC_LIN_BITS_LEGACY, lin)
    `CK("phys", PMC_PHYS_BITS_LEGACY, phys)
    `CK("asz", PMC_SZ_32, asz)
    `CK("gpc", PMC_GPR_LEGACY, gpc)
    @(posedge ref_clk);
    flags_register <= '0;
  endtask
  task automatic t_long();
    go(PMC_MODE_LONG64);
    `CK("mode", PMC_MODE_LONG64, cur_mode)
    `CK("asz", PMC_SZ_64, asz)
    `CK("osz", PMC_SZ_32, osz)
    `CK("lin", PMC_LIN_BITS_LONG, lin)
    `CK("gpc", PMC_GPR_LONG, gpc)
    `CK("smc", PMC_GPR_LONG, smc)
    `CK("gpw", PMC_GPR_W_LONG, gpw)
    `CK("ipw", PMC_GPR_W_LONG, ipw)
    `CK("flw", PMC_GPR_W_LONG, flw)
    @(posedge ref_clk);
    rex_w <= 1'b1;
    settle(3);
    `CK("osz", PMC_SZ_32, osz)
    @(posedge ref_clk);
    opsz <= 1'b1;
    settle(3);
    `CK("osz", PMC_SZ_64, osz)
    @(posedge ref_clk);
    rex_w <= 1'b0;
    opsz <= 1'b0;
  endtask
  task automatic t_mgmt();
    @(posedge ref_clk);
    live_ctx <= 64'h0123_4567_89ab_cdef;
    pulse(1'b1);
    `CK("mode", PMC_MODE_SYSMGT, cur_mode)
    `CK("sms", 1'b1, sms)
    `CK("mas", 1'b1, mas)
    pulse(1'b0);
    `CK("pend", 1'b1, pend)
    `CK("mode", PMC_MODE_SYSMGT, cur_mode)
    resume();
    `CK("stb", 1'b1, stb)
    `CK("ctx", 64'h0123_4567_89ab_cdef, ctx_restore)
    `CK("mode", PMC_MODE_LONG64, cur_mode)
    settle(1);
    `CK("stb", 1'b0, stb)
    `CK("mode", PMC_MODE_SYSMGT, cur_mode)
    resume();
    `CK("mode", PMC_MODE_LONG64, cur_mode)
    pulse(1'b0);
    `CK("mode", PMC_MODE_SYSMGT, cur_mode)
    `CK("pend", 1'b0, pend)
    resume();
    `CK("mode", PMC_MODE_LONG64, cur_mode)
  endtask
  task automatic t_boundary();
    @(posedge ref_clk);
    instr_boundary <= 1'b0;
    os_goal <= PMC_MODE_COMPAT;
    settle(4);
    `CK("mode", PMC_MODE_LONG64, cur_mode)
    @(posedge ref_clk);
    clk_en <= 1'b0;
    instr_boundary <= 1'b1;
    settle(4);
    `CK("mode", PMC_MODE_LONG64, cur_mode)
    @(posedge ref_clk);
    clk_en <= 1'b1;
    settle(3);
    `CK("mode", PMC_MODE_COMPAT, cur_mode)
  endtask
  task automatic test_done();
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  initial begin
    repeat (4) @(posedge ref_clk);
    rst <= 1'b0;
    settle(1);
    t_reset();
    t_prot_v86();
    t_compat();
    t_long();
    t_mgmt();
    t_boundary();
    test_done();
  end
  initial begin
    repeat (2000) @(posedge ref_clk);
    fails++;
    test_done();
  end
endmodule
